// [rtl/aac_pkg.sv]
// Package for access attribute and coherency state logic.
// Assumes a single core clock domain; shared by the main block and its state unit.
package aac_pkg;

	// Attribute set bit positions (write-through, inhibit, coherent, guarded)
	localparam int unsigned ATTR_W_BIT = 3;
	localparam int unsigned ATTR_I_BIT = 2;
	localparam int unsigned ATTR_M_BIT = 1;
	localparam int unsigned ATTR_G_BIT = 0;
	localparam logic [3:0] ATTR_REAL_MODE = 4'h3;

	// L1 data cache state encodings
	localparam logic [2:0] L1_MODIFIED = 3'h6;
	localparam logic [2:0] L1_EXCLUSIVE = 3'h4;
	localparam logic [2:0] L1_SHARED = 3'h5;
	localparam logic [2:0] L1_INVALID = 3'h0;
	localparam int unsigned L1_VALID_BIT = 2;

	// L2 cache state encodings
	localparam logic [1:0] L2_MODIFIED = 2'h3;
	localparam logic [1:0] L2_EXCLUSIVE = 2'h2;
	localparam logic [1:0] L2_SHARED = 2'h1;
	localparam logic [1:0] L2_INVALID = 2'h0;

	// Fetch limit and block state table size
	localparam logic [1:0] FETCH_MAX_OUTSTANDING = 2'h2;
	localparam int unsigned BLOCK_ENTRIES = 16;
	localparam int unsigned BLOCK_IDX_W = 4;

	typedef struct packed {
		logic write_through;
		logic cache_inhibit;
		logic coherent;
		logic guarded;
	} aac_attr_t;

	typedef enum logic [2:0] {
		AAC_EV_NONE,
		AAC_EV_RELOAD,
		AAC_EV_STORE_HIT,
		AAC_EV_CACHE_OP_HIT,
		AAC_EV_SNOOP_CLEAN,
		AAC_EV_SNOOP_INVAL,
		AAC_EV_SNOOP_READ
	} aac_event_t;

	typedef struct packed {
		aac_event_t kind;
		logic [3:0] idx;
		logic store_miss;
		logic load_miss;
		logic from_l2;
		logic shared_resp;
		logic l2_src_shared;
		logic write_back;
	} aac_cevent_t;

endpackage

// [rtl/aac_state_unit.sv]
// State store for L1 data and L2 cache blocks, with set and clear conditions.
// Assumes one event per cycle from the main block, on the core clock.
module aac_state_unit (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire aac_pkg::aac_cevent_t ev,
	input wire logic [aac_pkg::BLOCK_IDX_W-1:0] rd_idx,
	output logic [2:0] l1_state_q,
	output logic [1:0] l2_state_q
);
	logic [2:0] l1_mem [aac_pkg::BLOCK_ENTRIES];
	logic [1:0] l2_mem [aac_pkg::BLOCK_ENTRIES];
	logic [2:0] l1_d;
	logic [1:0] l2_d;
	logic [2:0] cur_l1;
	logic [1:0] cur_l2;

	function automatic logic l1_valid(input logic [2:0] s);
		return s[aac_pkg::L1_VALID_BIT];
	endfunction

	assign cur_l1 = l1_mem[ev.idx];
	assign cur_l2 = l2_mem[ev.idx];

	always_comb begin
		l1_d = cur_l1;
		l2_d = cur_l2;
		case (ev.kind)
			aac_pkg::AAC_EV_RELOAD: begin
				if (ev.store_miss) begin
					l1_d = aac_pkg::L1_MODIFIED;
					l2_d = aac_pkg::L2_MODIFIED;
				end else if (ev.load_miss && ((!ev.from_l2 && ev.shared_resp) ||
						(ev.from_l2 && ev.l2_src_shared))) begin
					l1_d = aac_pkg::L1_SHARED;
					if (!ev.from_l2)
						l2_d = aac_pkg::L2_SHARED;
				end else begin
					l1_d = aac_pkg::L1_EXCLUSIVE;
					if (!ev.from_l2)
						l2_d = aac_pkg::L2_EXCLUSIVE;
				end
			end
			aac_pkg::AAC_EV_STORE_HIT: begin
				if (ev.write_back && l1_valid(cur_l1)) begin
					if (cur_l1 != aac_pkg::L1_SHARED)
						l1_d = aac_pkg::L1_MODIFIED;
					else
						l1_d = aac_pkg::L1_INVALID;
				end
			end
			aac_pkg::AAC_EV_CACHE_OP_HIT: begin
				l1_d = aac_pkg::L1_INVALID;
				l2_d = aac_pkg::L2_INVALID;
			end
			aac_pkg::AAC_EV_SNOOP_CLEAN: begin
				if (l1_valid(cur_l1) && cur_l1 != aac_pkg::L1_SHARED)
					l1_d = aac_pkg::L1_SHARED;
				if (cur_l2 == aac_pkg::L2_MODIFIED || cur_l2 == aac_pkg::L2_EXCLUSIVE)
					l2_d = aac_pkg::L2_SHARED;
			end
			aac_pkg::AAC_EV_SNOOP_INVAL: begin
				l1_d = aac_pkg::L1_INVALID;
				l2_d = aac_pkg::L2_INVALID;
			end
			aac_pkg::AAC_EV_SNOOP_READ: begin
				if (cur_l1 == aac_pkg::L1_MODIFIED || cur_l1 == aac_pkg::L1_EXCLUSIVE)
					l1_d = aac_pkg::L1_SHARED;
				if (cur_l2 == aac_pkg::L2_MODIFIED || cur_l2 == aac_pkg::L2_EXCLUSIVE)
					l2_d = aac_pkg::L2_SHARED;
			end
			default: begin
				l1_d = cur_l1;
				l2_d = cur_l2;
			end
		endcase
	end

	// Each level keeps its own state independently
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < aac_pkg::BLOCK_ENTRIES; i++) begin
				l1_mem[i] <= aac_pkg::L1_INVALID;
				l2_mem[i] <= aac_pkg::L2_INVALID;
			end
		end else if (ev.kind != aac_pkg::AAC_EV_NONE) begin
			l1_mem[ev.idx] <= l1_d;
			l2_mem[ev.idx] <= l2_d;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			l1_state_q <= aac_pkg::L1_INVALID;
			l2_state_q <= aac_pkg::L2_INVALID;
		end else begin
			l1_state_q <= l1_mem[rd_idx];
			l2_state_q <= l2_mem[rd_idx];
		end
	end
endmodule

// [rtl/aac_core.sv]
// Access attribute handling, guarded fetch/load gating and coherency events.
// Assumes requests come from core logic on ref_clk; strobes are single-cycle.
//
// Behaviour
// - Translation off forces attributes to 0011
// - Block-translated fetches are always unguarded
// - Coherent attribute selects global bus transaction
// - Translated guarded fetch raises storage fault
// - Untranslated guarded fetch needs cache/page locality
// - At most two fetches outstanding
// - Stores issue only when execution requires them
// - Guarded inhibited stores never gathered
// - Guarded load reorders only if cached/certain
// - Speculation disable holds fetches and loads
// - Uncached guarded load waits for oldest, loads drained
// - Own bus transactions are snooped, conditional stores retried
// - L1 state: 110 M, 100 E, 101 S
// - L2 state: 11 M, 10 E, 01 S
// - Store miss reload or write-back store hit to exclusive modifies
// - Unshared reload enters exclusive
// - Shared-indicated load reload enters shared
// - Snoops and cache ops leave modified/exclusive
// - L1 and L2 states held independently
module aac_core (
	input wire logic ref_clk,
	input wire logic arst_n,
	input wire logic instr_translate_enable,
	input wire logic data_translate_enable,
	input wire logic speculation_disable,
	// Instruction fetch request
	input wire logic fetch_req,
	input wire aac_pkg::aac_attr_t fetch_attr,
	input wire logic fetch_via_block,
	input wire logic fetch_in_icache,
	input wire logic fetch_same_page,
	input wire logic fetch_next_page,
	input wire logic fetch_required,
	input wire logic fetch_done,
	output logic fetch_issue,
	output logic fetch_stall,
	output logic instr_storage_fault_q,
	output logic fetch_global_q,
	output aac_pkg::aac_attr_t fetch_attr_q,
	// Data load request
	input wire logic load_req,
	input wire aac_pkg::aac_attr_t load_attr,
	input wire logic load_in_dcache,
	input wire logic load_certain,
	input wire logic load_oldest,
	input wire logic load_data_return,
	output logic load_issue,
	output logic load_stall,
	output logic load_block_fill_q,
	output logic load_global_q,
	output aac_pkg::aac_attr_t load_attr_q,
	// Data store request
	input wire logic store_req,
	input wire aac_pkg::aac_attr_t store_attr,
	input wire logic store_required,
	output logic store_issue,
	output logic store_stall,
	output logic store_gather_ok_q,
	output logic store_global_q,
	// Own bus transactions and snoops
	input wire logic bus_tx_valid,
	input wire logic bus_tx_own,
	input wire logic bus_tx_cond_store,
	input wire logic bus_tx_collision,
	output logic snoop_retry_q,
	// Coherency events
	input wire aac_pkg::aac_cevent_t cache_event,
	input wire logic [aac_pkg::BLOCK_IDX_W-1:0] state_rd_idx,
	output logic [2:0] l1_state_q,
	output logic [1:0] l2_state_q
);
	aac_pkg::aac_attr_t fetch_eff;
	aac_pkg::aac_attr_t load_eff;
	aac_pkg::aac_attr_t store_eff;
	logic [1:0] fetch_out_q;
	logic [1:0] fetch_out_d;
	logic [3:0] load_out_q;
	logic [3:0] load_out_d;
	logic fetch_ok;
	logic fetch_fault;
	logic load_ok;
	logic snoop_retry_d;

	// Real mode overrides page and block attributes
	function automatic aac_pkg::aac_attr_t eff_attr(input logic xlate_on,
			input aac_pkg::aac_attr_t a);
		if (!xlate_on)
			return aac_pkg::aac_attr_t'(aac_pkg::ATTR_REAL_MODE);
		return a;
	endfunction

	always_comb begin
		fetch_eff = eff_attr(instr_translate_enable, fetch_attr);
		if (instr_translate_enable && fetch_via_block)
			fetch_eff.guarded = 1'b0;
	end

	assign load_eff = eff_attr(data_translate_enable, load_attr);
	assign store_eff = eff_attr(data_translate_enable, store_attr);

	// Fetch gating
	always_comb begin
		fetch_fault = fetch_req && instr_translate_enable && fetch_eff.guarded;
		fetch_ok = 1'b1;
		if (fetch_eff.guarded && !instr_translate_enable)
			fetch_ok = fetch_in_icache || fetch_same_page || fetch_next_page;
		if (speculation_disable && !fetch_required)
			fetch_ok = 1'b0;
		if (fetch_out_q >= aac_pkg::FETCH_MAX_OUTSTANDING && !fetch_in_icache)
			fetch_ok = 1'b0;
		if (fetch_fault)
			fetch_ok = 1'b0;
	end

	assign fetch_issue = fetch_req && fetch_ok;
	assign fetch_stall = fetch_req && !fetch_ok && !fetch_fault;

	always_comb begin
		fetch_out_d = fetch_out_q;
		if (fetch_issue && !fetch_in_icache && !fetch_done)
			fetch_out_d = fetch_out_q + 2'h1;
		else if (!(fetch_issue && !fetch_in_icache) && fetch_done && fetch_out_q != 2'h0)
			fetch_out_d = fetch_out_q - 2'h1;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			fetch_out_q <= 2'h0;
		else
			fetch_out_q <= fetch_out_d;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			instr_storage_fault_q <= 1'b0;
			fetch_global_q <= 1'b0;
			fetch_attr_q <= '0;
		end else begin
			instr_storage_fault_q <= fetch_fault;
			if (fetch_issue) begin
				fetch_global_q <= fetch_eff.coherent;
				fetch_attr_q <= fetch_eff;
			end
		end
	end

	// Load gating
	always_comb begin
		load_ok = 1'b1;
		if (load_eff.guarded && !load_in_dcache) begin
			if (!load_certain)
				load_ok = 1'b0;
			if (!load_oldest || load_out_q != 4'h0)
				load_ok = 1'b0;
		end
		if (speculation_disable && !load_certain && !load_in_dcache)
			load_ok = 1'b0;
	end

	assign load_issue = load_req && load_ok;
	assign load_stall = load_req && !load_ok;

	always_comb begin
		load_out_d = load_out_q;
		if (load_issue && !load_in_dcache && !load_data_return)
			load_out_d = load_out_q + 4'h1;
		else if (!(load_issue && !load_in_dcache) && load_data_return && load_out_q != 4'h0)
			load_out_d = load_out_q - 4'h1;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			load_out_q <= 4'h0;
		else
			load_out_q <= load_out_d;
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			load_block_fill_q <= 1'b0;
			load_global_q <= 1'b0;
			load_attr_q <= '0;
		end else if (load_issue) begin
			load_block_fill_q <= load_eff.guarded && load_certain &&
				!load_eff.cache_inhibit;
			load_global_q <= load_eff.coherent;
			load_attr_q <= load_eff;
		end
	end

	// Stores: never speculative, loads may bypass them
	assign store_issue = store_req && store_required;
	assign store_stall = store_req && !store_required;

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			store_gather_ok_q <= 1'b0;
			store_global_q <= 1'b0;
		end else if (store_issue) begin
			store_gather_ok_q <= !(store_eff.guarded && store_eff.cache_inhibit);
			store_global_q <= store_eff.coherent;
		end
	end

	// Self-snoop: own conditional store broadcasts can be retried
	assign snoop_retry_d = bus_tx_valid && bus_tx_collision &&
		(!bus_tx_own || bus_tx_cond_store);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n)
			snoop_retry_q <= 1'b0;
		else
			snoop_retry_q <= snoop_retry_d;
	end

	aac_state_unit u_state (
		.ref_clk(ref_clk),
		.arst_n(arst_n),
		.ev(cache_event),
		.rd_idx(state_rd_idx),
		.l1_state_q(l1_state_q),
		.l2_state_q(l2_state_q)
	);
endmodule

// [test/aac_core_sva.sv]
// Checker for aac_core port behaviour.
// Bound to every aac_core instance; single core clock domain.
module aac_core_sva (
	input wire logic ref_clk, arst_n, instr_translate_enable, data_translate_enable,
	input wire logic speculation_disable, fetch_required, store_global_q,
	input wire logic fetch_req, fetch_via_block, fetch_issue, instr_storage_fault_q,
	input wire aac_pkg::aac_attr_t fetch_attr, fetch_attr_q, load_attr, store_attr,
	input wire logic load_in_dcache, load_oldest, load_issue, load_global_q,
	input wire logic store_required, store_issue, store_gather_ok_q, snoop_retry_q,
	input wire logic bus_tx_valid, bus_tx_own, bus_tx_cond_store, bus_tx_collision
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);
	AST_REAL_MODE: assert property (
		fetch_issue && !instr_translate_enable |=> fetch_attr_q == aac_pkg::ATTR_REAL_MODE)
		else $error("real mode attributes wrong");
	AST_BLOCK_UNGUARDED: assert property (
		fetch_req && instr_translate_enable && fetch_via_block |=> !instr_storage_fault_q)
		else $error("block fetch faulted");
	AST_LOAD_GLOBAL: assert property (
		load_issue |=> load_global_q == ($past(load_attr.coherent) || !$past(data_translate_enable)))
		else $error("load global wrong");
	AST_GUARD_FAULT: assert property (
		fetch_req && instr_translate_enable && fetch_attr.guarded && !fetch_via_block
		|-> !fetch_issue ##1 instr_storage_fault_q) else $error("guarded fetch not faulted");
	AST_STORE_REQUIRED: assert property (
		store_issue |-> store_required) else $error("store issued early");
	AST_NO_GATHER: assert property (
		store_issue && data_translate_enable && store_attr.guarded && store_attr.cache_inhibit
		|=> !store_gather_ok_q) else $error("guarded inhibited store gatherable");
	AST_GUARD_OLDEST: assert property (
		load_issue && !load_in_dcache && (load_attr.guarded || !data_translate_enable)
		|-> load_oldest) else $error("guarded load not oldest");
	AST_STORE_GLOBAL: assert property (
		store_issue |=> store_global_q ==
		($past(store_attr.coherent) || !$past(data_translate_enable)))
		else $error("store global wrong");
	AST_SPEC_HOLD: assert property (
		speculation_disable && !fetch_required |-> !fetch_issue)
		else $error("speculative fetch issued");
	AST_SELF_RETRY: assert property (
		bus_tx_valid && bus_tx_own && bus_tx_cond_store && bus_tx_collision
		|=> snoop_retry_q) else $error("own conditional store not retried");
endmodule
bind aac_core aac_core_sva i_sva (.*);

// [test/aac_bus_model.sv]
// Bus-side model: returns each fetch and load miss, held back while hold is high.
// Assumes miss strobes are one cycle per issued transfer.
module aac_bus_model (
	input wire logic ref_clk, arst_n, fetch_miss, load_miss, hold,
	output logic fetch_done, load_data_return
);
	logic [2:0] fpend_q, lpend_q;
	assign fetch_done = !hold && fpend_q != 3'h0;
	assign load_data_return = !hold && lpend_q != 3'h0;
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			fpend_q <= 3'h0;
			lpend_q <= 3'h0;
		end else begin
			fpend_q <= fpend_q + {2'h0, fetch_miss} - {2'h0, fetch_done};
			lpend_q <= lpend_q + {2'h0, load_miss} - {2'h0, load_data_return};
		end
	end
endmodule

// [test/aac_core_tb.sv]
// Self-checking bench for aac_core with a bus return model.
// Assumes the checker is bound from its own file.
module aac_core_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic ite; logic [3:0] a; logic blk; logic flt; logic [3:0] ea;} aac_row_t;
	logic ref_clk = 0, arst_n = 0, instr_translate_enable = 1, data_translate_enable = 1;
	logic speculation_disable = 0, fetch_req = 0, fetch_via_block = 0, fetch_in_icache = 1;
	logic fetch_same_page = 1, fetch_next_page = 0, fetch_required = 0, fetch_done, hold = 0;
	logic fetch_issue, fetch_stall, instr_storage_fault_q, fetch_global_q;
	aac_pkg::aac_attr_t fetch_attr = '0, fetch_attr_q, load_attr = '0, load_attr_q, store_attr = '0;
	logic load_req = 0, load_in_dcache = 0, load_certain = 0, load_oldest = 1, load_data_return;
	logic load_issue, load_stall, load_block_fill_q, load_global_q, store_gather_ok_q;
	logic store_req = 0, store_required = 0, store_issue, store_stall, store_global_q;
	logic bus_tx_valid = 0, bus_tx_own = 1, bus_tx_cond_store = 1, bus_tx_collision = 1;
	logic snoop_retry_q;
	aac_pkg::aac_cevent_t cache_event = '0;
	logic [3:0] state_rd_idx = 4'h0;
	logic [2:0] l1_state_q;
	logic [1:0] l2_state_q;
	int err_count = 0, num_checks = 0, n, k;
	aac_row_t rows [5] = '{'{1'h0, 4'h0, 1'h0, 1'h0, 4'h3}, '{1'h1, 4'h8, 1'h0, 1'h0, 4'h8},
		'{1'h1, 4'h2, 1'h0, 1'h0, 4'h2}, '{1'h1, 4'h1, 1'h0, 1'h1, 4'h0},
		'{1'h1, 4'h3, 1'h1, 1'h0, 4'h2}};
	aac_core i_dut (.*);
	aac_bus_model i_bus (.ref_clk(ref_clk), .arst_n(arst_n), .hold(hold),
		.fetch_miss(fetch_issue && !fetch_in_icache), .load_miss(load_issue && !load_in_dcache),
		.fetch_done(fetch_done), .load_data_return(load_data_return));
	initial forever #12.5 ref_clk = ~ref_clk;
	task cyc;
		@(posedge ref_clk);
		#2;
	endtask
	task chk(input logic ok, input string m);
		num_checks++;
		if (ok !== 1'b1) begin
			err_count++;
			$display("[FAIL] %0t %s", $time, m);
		end
	endtask
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	task ev(input aac_pkg::aac_event_t t, input logic [3:0] i, input logic [5:0] f,
		input logic [2:0] e1, input logic [1:0] e2);
		cache_event = '{t, i, f[5], f[4], f[3], f[2], f[1], f[0]};
		state_rd_idx = i;
		cyc;
		cache_event = '0;
		cyc;
		chk(l1_state_q === e1 && l2_state_q === e2, "block state");
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		#2 arst_n = 1;
		chk(l1_state_q === 3'h0 && instr_storage_fault_q === 1'b0, "reset values");
		foreach (rows[j]) begin
			instr_translate_enable = rows[j].ite;
			fetch_attr = rows[j].a;
			fetch_via_block = rows[j].blk;
			fetch_req = 1;
			#1 chk(fetch_issue === !rows[j].flt, "fetch issue");
			cyc;
			chk(instr_storage_fault_q === rows[j].flt, "fault");
			if (!rows[j].flt) chk(fetch_attr_q === rows[j].ea && fetch_global_q === rows[j].ea[1],
				"fetch attr");
		end
		{instr_translate_enable, fetch_in_icache, fetch_same_page, fetch_req} = 4'h1;
		#1 chk(fetch_stall === 1'b1 && fetch_issue === 1'b0, "guarded fetch held");
		for (k = 0; k < 3; k++) begin
			{fetch_in_icache, fetch_same_page, fetch_next_page} = 3'h4 >> k;
			#1 chk(fetch_issue === 1'b1, "local fetch");
		end
		{instr_translate_enable, fetch_in_icache, fetch_attr} = 6'h00;
		hold = 1;
		n = 0;
		#1;
		repeat (3) begin
			n += fetch_issue;
			cyc;
		end
		chk(n == 2 && fetch_stall === 1'b1, "outstanding limit");
		hold = 0;
		for (k = 0; k < 8 && !fetch_issue; k++) cyc;
		chk(fetch_issue, "fetch resumes after return");
		if (!fetch_issue) begin
			print_verdict;
		end
		fetch_req = 0;
		repeat (5) cyc;
		{speculation_disable, fetch_req} = 2'h3;
		#1 chk(fetch_stall === 1'b1, "speculative fetch held");
		fetch_required = 1;
		#1 chk(fetch_issue === 1'b1, "required fetch");
		{fetch_req, speculation_disable, hold} = 3'h1;
		// Uncached guarded loads wait until certain and drained, then fill the whole block
		load_attr = 4'h1;
		load_req = 1;
		#1 chk(load_stall === 1'b1, "uncertain guarded load");
		load_certain = 1;
		#1 chk(load_issue === 1'b1, "certain guarded load");
		cyc;
		chk(load_stall === 1'b1, "guarded behind outstanding");
		chk(load_block_fill_q === 1'b1 && load_attr_q === 4'h1 && load_global_q === 1'b0,
			"block fill");
		{load_req, hold, load_certain, load_oldest, load_in_dcache} = 5'h1;
		cyc;
		cyc;
		load_req = 1;
		#1 chk(load_issue === 1'b1, "guarded cached load");
		{load_req, store_attr, store_req} = 6'hb;
		#1 chk(store_stall === 1'b1 && store_issue === 1'b0, "store waits");
		store_required = 1;
		cyc;
		chk(store_gather_ok_q === 1'b0 && store_global_q === 1'b0, "no gather");
		store_attr = 4'h6;
		cyc;
		chk(store_gather_ok_q === 1'b1 && store_global_q === 1'b1, "gather allowed");
		store_req = 0;
		bus_tx_valid = 1;
		cyc;
		chk(snoop_retry_q === 1'b1, "self retry");
		bus_tx_cond_store = 0;
		cyc;
		bus_tx_valid = 0;
		chk(snoop_retry_q === 1'b0, "no retry");
		ev(aac_pkg::AAC_EV_RELOAD, 4'h3, 6'h20, aac_pkg::L1_MODIFIED, aac_pkg::L2_MODIFIED);
		ev(aac_pkg::AAC_EV_RELOAD, 4'h4, 6'h14, aac_pkg::L1_SHARED, aac_pkg::L2_SHARED);
		ev(aac_pkg::AAC_EV_RELOAD, 4'h5, 6'h10, aac_pkg::L1_EXCLUSIVE, aac_pkg::L2_EXCLUSIVE);
		ev(aac_pkg::AAC_EV_STORE_HIT, 4'h5, 6'h01, aac_pkg::L1_MODIFIED, aac_pkg::L2_EXCLUSIVE);
		ev(aac_pkg::AAC_EV_SNOOP_CLEAN, 4'h3, 6'h00, aac_pkg::L1_SHARED, aac_pkg::L2_SHARED);
		ev(aac_pkg::AAC_EV_SNOOP_INVAL, 4'h4, 6'h00, aac_pkg::L1_INVALID, aac_pkg::L2_INVALID);
		ev(aac_pkg::AAC_EV_CACHE_OP_HIT, 4'h5, 6'h00, aac_pkg::L1_INVALID, aac_pkg::L2_INVALID);
		ev(aac_pkg::AAC_EV_STORE_HIT, 4'h3, 6'h01, aac_pkg::L1_INVALID, aac_pkg::L2_SHARED);
		ev(aac_pkg::AAC_EV_RELOAD, 4'h6, 6'h10, aac_pkg::L1_EXCLUSIVE, aac_pkg::L2_EXCLUSIVE);
		ev(aac_pkg::AAC_EV_SNOOP_READ, 4'h6, 6'h00, aac_pkg::L1_SHARED, aac_pkg::L2_SHARED);
		ev(aac_pkg::AAC_EV_RELOAD, 4'h7, 6'h1a, aac_pkg::L1_SHARED, aac_pkg::L2_INVALID);
		arst_n = 0;
		cyc;
		arst_n = 1;
		state_rd_idx = 4'h3;
		cyc;
		cyc;
		chk(l1_state_q === 3'h0 && l2_state_q === 2'h0, "mid-run reset");
		print_verdict;
	end
endmodule
